// ### verilog/tir_regs.v
/*
 * integration-test registers of a program-flow trace unit, reached over
 * the unit's debug apb slave port, plus its constant power-down status.
 * assumes the apb master runs on clk and that functional trace logic
 * supplies the normal values of every overridable pin.
 */
//
// Behaviour
// - power-down status always reads one: trace registers reachable.
// - bit 0 of integration control enters integration mode; reset clears it.
// - in integration mode, write-only test values drive their mapped pins.
// - in integration mode, read-only test registers return live input pins.
// - misc output bits 9:8 ext outputs, 5 idle ack, 4 debug request.
// - misc input bit 5 standby, 4 debug ack, 3:0 ext inputs.
// - trigger register bit 0 drives trigger output; rest reserved.
// - data bits 4..0 drive trace data bits 31,23,15,7,0.
// - bus input register: bit 1 flush valid, bit 0 ready, rest zero.
// - trace id register bits 6:0 drive trace source id.
// - bus control bits 9:8 byte count, 1 flush ready, 0 valid.
//
`timescale 1ns/1ps
`default_nettype none
`include "tir_map.vh"

module tir_regs (
   // clock and reset
   input  wire        clk,
   input  wire        srst,
   // debug apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire [11:2] paddr,
   input  wire        pwrite,
   input  wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // functional values of overridable outputs
   input  wire [1:0]  func_ext_output_resource,
   input  wire        func_idle_ack_n,
   input  wire        func_debug_request_out,
   input  wire        func_trigger_occurred_out,
   input  wire [31:0] func_trace_data_out,
   input  wire [6:0]  func_trace_source_id_out,
   input  wire [1:0]  func_trace_byte_count_out,
   input  wire        func_flush_ready_out,
   input  wire        func_trace_valid_out,
   // output pins
   output wire [1:0]  ext_output_resource,
   output wire        idle_ack_n,
   output wire        debug_request_out,
   output wire        trigger_occurred_out,
   output wire [31:0] trace_data_out,
   output wire [6:0]  trace_source_id_out,
   output wire [1:0]  trace_byte_count_out,
   output wire        flush_ready_out,
   output wire        trace_valid_out,
   // input pins
   input  wire        cpu_wfi_standby,
   input  wire        debug_ack_in,
   input  wire [3:0]  ext_input_resource,
   input  wire        flush_valid_in,
   input  wire        trace_ready_in,
   // mode status for the functional logic
   output wire        integration_mode
);

// ==========================================================================
// state
reg        int_mode_q;
reg [1:0]  ext_out_q;
reg        idle_ack_n_q;
reg        dbg_req_q;
reg        trig_q;
reg [4:0]  data_bits_q;
reg [6:0]  trace_id_q;
reg [1:0]  byte_cnt_q;
reg        flush_ready_q;
reg        trace_valid_q;
reg [31:0] prdata_q;
reg [31:0] rd_data_d;

wire [11:0] byte_addr;
wire        wr_en;
wire        rd_setup;

// ==========================================================================
// apb handshake
// the slave never stretches a transfer and never signals an error
assign byte_addr = {paddr, 2'h0};
assign wr_en     = psel & penable & pwrite;
assign rd_setup  = psel & ~penable & ~pwrite;
assign pready    = 1'h1;
assign pslverr   = 1'h0;
assign prdata    = prdata_q;
assign integration_mode = int_mode_q;

// ==========================================================================
// register writes
// overrides are stored even outside integration mode; they only reach
// the pins once the mode bit is set, so software may preload them
always @(posedge clk) begin
   if (srst) begin
      int_mode_q    <= `TIR_INT_MODE_RST;
      ext_out_q     <= {2{`TIR_OVR_RST}};
      idle_ack_n_q  <= `TIR_OVR_RST;
      dbg_req_q     <= `TIR_OVR_RST;
      trig_q        <= `TIR_OVR_RST;
      data_bits_q   <= {5{`TIR_OVR_RST}};
      trace_id_q    <= {7{`TIR_OVR_RST}};
      byte_cnt_q    <= {2{`TIR_OVR_RST}};
      flush_ready_q <= `TIR_OVR_RST;
      trace_valid_q <= `TIR_OVR_RST;
   end else if (wr_en) begin
      if (byte_addr == `TIR_OFS_INT_MODE) begin
         int_mode_q <= pwdata[`TIR_INT_MODE_BIT];
      end else if (byte_addr == `TIR_OFS_MISC_OUT) begin
         // reserved bits are simply not stored
         ext_out_q    <= pwdata[`TIR_MO_EXT_HI:`TIR_MO_EXT_LO];
         idle_ack_n_q <= pwdata[`TIR_MO_IDLE_ACK];
         dbg_req_q    <= pwdata[`TIR_MO_DBG_REQ];
      end else if (byte_addr == `TIR_OFS_TRIG_OUT) begin
         trig_q <= pwdata[`TIR_TR_TRIG];
      end else if (byte_addr == `TIR_OFS_DATA_BITS) begin
         data_bits_q <= pwdata[`TIR_DB_HI:`TIR_DB_LO];
      end else if (byte_addr == `TIR_OFS_TRACE_ID) begin
         trace_id_q <= pwdata[`TIR_ID_HI:`TIR_ID_LO];
      end else if (byte_addr == `TIR_OFS_BUS_CTRL) begin
         byte_cnt_q    <= pwdata[`TIR_BC_BYTES_HI:`TIR_BC_BYTES_LO];
         flush_ready_q <= pwdata[`TIR_BC_FLUSH_READY];
         trace_valid_q <= pwdata[`TIR_BC_VALID];
      end
   end
end

// ==========================================================================
// read decode
// input samples read as zero outside integration mode, so a stray read
// cannot be mistaken for a pin check; write-only registers read zero
always @* begin
   rd_data_d = 32'h00000000;
   if (byte_addr == `TIR_OFS_PWR_STATUS) begin
      rd_data_d = `TIR_PWR_STATUS_VAL;
   end else if (byte_addr == `TIR_OFS_INT_MODE) begin
      rd_data_d[`TIR_INT_MODE_BIT] = int_mode_q;
   end else if (byte_addr == `TIR_OFS_MISC_IN) begin
      if (int_mode_q) begin
         rd_data_d[`TIR_MI_STANDBY] = cpu_wfi_standby;
         rd_data_d[`TIR_MI_DBG_ACK] = debug_ack_in;
         rd_data_d[`TIR_MI_EXT_HI:`TIR_MI_EXT_LO] = ext_input_resource;
      end
   end else if (byte_addr == `TIR_OFS_BUS_IN) begin
      if (int_mode_q) begin
         rd_data_d[`TIR_BI_FLUSH_VALID] = flush_valid_in;
         rd_data_d[`TIR_BI_READY]       = trace_ready_in;
      end
   end
end

// ==========================================================================
// read data register
// captured in the setup phase so prdata is a flop during the access phase
always @(posedge clk) begin
   if (srst) begin
      prdata_q <= 32'h00000000;
   end else if (rd_setup) begin
      prdata_q <= rd_data_d;
   end
end

// ==========================================================================
// pin overrides
// unmapped trace data bits are driven low while overriding
wire [47:0] func_vec;
wire [47:0] ovr_vec;
wire [47:0] pin_vec;
wire [31:0] ovr_data;

assign ovr_data = {data_bits_q[4], 7'h00, data_bits_q[3], 7'h00,
                   data_bits_q[2], 7'h00, data_bits_q[1], 6'h00,
                   data_bits_q[0]};

assign func_vec = {func_ext_output_resource, func_idle_ack_n,
                   func_debug_request_out, func_trigger_occurred_out,
                   func_trace_data_out, func_trace_source_id_out,
                   func_trace_byte_count_out, func_flush_ready_out,
                   func_trace_valid_out};

assign ovr_vec = {ext_out_q, idle_ack_n_q, dbg_req_q, trig_q, ovr_data,
                  trace_id_q, byte_cnt_q, flush_ready_q, trace_valid_q};

tir_out_mux #(
   .W (48)
) u_out_mux (
   .sel      (int_mode_q),
   .func_val (func_vec),
   .ovr_val  (ovr_vec),
   .pin_val  (pin_vec)
);

assign ext_output_resource  = pin_vec[47:46];
assign idle_ack_n           = pin_vec[45];
assign debug_request_out    = pin_vec[44];
assign trigger_occurred_out = pin_vec[43];
assign trace_data_out       = pin_vec[42:11];
assign trace_source_id_out  = pin_vec[10:4];
assign trace_byte_count_out = pin_vec[3:2];
assign flush_ready_out      = pin_vec[1];
assign trace_valid_out      = pin_vec[0];

endmodule

`default_nettype wire

// ### verilog/tir_map.vh
/*
 * register map of the trace integration-test register set: byte offsets,
 * field positions, reset values and constant read values.
 * assumes the includer compares offsets against a 12-bit byte address
 * built from the word address of the debug register port.
 */
`ifndef TIR_MAP_VH
`define TIR_MAP_VH

// ==========================================================================
// byte offsets
`define TIR_OFS_MISC_OUT        12'hEDC
`define TIR_OFS_MISC_IN         12'hEE0
`define TIR_OFS_TRIG_OUT        12'hEE8
`define TIR_OFS_DATA_BITS       12'hEEC
`define TIR_OFS_BUS_IN          12'hEF0
`define TIR_OFS_TRACE_ID        12'hEF4
`define TIR_OFS_BUS_CTRL        12'hEF8
`define TIR_OFS_INT_MODE        12'hF00
`define TIR_OFS_PWR_STATUS      12'h314

// ==========================================================================
// constant and reset values
`define TIR_PWR_STATUS_VAL      32'h00000001
`define TIR_INT_MODE_RST        1'h0
`define TIR_OVR_RST             1'h0

// ==========================================================================
// field positions
`define TIR_INT_MODE_BIT        0
`define TIR_MO_EXT_HI           9
`define TIR_MO_EXT_LO           8
`define TIR_MO_IDLE_ACK         5
`define TIR_MO_DBG_REQ          4
`define TIR_MI_STANDBY          5
`define TIR_MI_DBG_ACK          4
`define TIR_MI_EXT_HI           3
`define TIR_MI_EXT_LO           0
`define TIR_TR_TRIG             0
`define TIR_DB_HI               4
`define TIR_DB_LO               0
`define TIR_BI_FLUSH_VALID      1
`define TIR_BI_READY            0
`define TIR_ID_HI               6
`define TIR_ID_LO               0
`define TIR_BC_BYTES_HI         9
`define TIR_BC_BYTES_LO         8
`define TIR_BC_FLUSH_READY      1
`define TIR_BC_VALID            0

`endif

// ### verilog/tir_out_mux.v
/*
 * per-bit selector between functional pin values and test overrides.
 * assumes sel is a registered mode bit, so the pins change cleanly.
 */
`timescale 1ns/1ps
`default_nettype none

module tir_out_mux #(
   parameter W = 48
) (
   // control
   input  wire         sel,
   // sources
   input  wire [W-1:0] func_val,
   input  wire [W-1:0] ovr_val,
   // pins
   output wire [W-1:0] pin_val
);

// ==========================================================================
// bit selectors
genvar i;
generate
   for (i = 0; i < W; i = i + 1) begin : g_bit
      assign pin_val[i] = sel ? ovr_val[i] : func_val[i];
   end
endgenerate

endmodule

`default_nettype wire

// ### verification/tir_regs_props.sv
/*
 * concurrent checks on the ports of the integration-test register block.
 * assumes one clock domain with synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module tir_regs_props (
   // clock, reset and apb
   input wire        clk,
   input wire        srst,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:2] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   // pins and mode
   input wire        integration_mode,
   input wire [1:0]  ext_output_resource,
   input wire        idle_ack_n,
   input wire        debug_request_out,
   input wire        trigger_occurred_out,
   input wire [31:0] trace_data_out,
   input wire [6:0]  trace_source_id_out,
   input wire [1:0]  trace_byte_count_out,
   input wire        flush_ready_out,
   input wire        trace_valid_out,
   input wire        func_trace_valid_out
);
   // ==========================================
   // transfer decode
   wire wr = psel && penable && pwrite;
   wire rs = psel && !penable && !pwrite;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // ==========================================
   // checks
   property p_pwr; rs && paddr == 10'h0C5 |=> prdata == 32'h00000001; endproperty
   a_pwr: assert property (p_pwr) else $error("power status not one");
   property p_mode; wr && paddr == 10'h3C0 |=> integration_mode == $past(pwdata[0]); endproperty
   a_mode: assert property (p_mode) else $error("mode bit not taken");
   property p_misc; wr && paddr == 10'h3B7 |=> !integration_mode || {ext_output_resource,
      idle_ack_n, debug_request_out} == {$past(pwdata[9:8]), $past(pwdata[5:4])}; endproperty
   a_misc: assert property (p_misc) else $error("misc pins wrong");
   property p_trig; wr && paddr == 10'h3BA |=> !integration_mode ||
      trigger_occurred_out == $past(pwdata[0]); endproperty
   a_trig: assert property (p_trig) else $error("trigger pin wrong");
   property p_data; wr && paddr == 10'h3BB |=> !integration_mode || {trace_data_out[31],
      trace_data_out[23], trace_data_out[15], trace_data_out[7], trace_data_out[0]}
      == $past(pwdata[4:0]); endproperty
   a_data: assert property (p_data) else $error("data pins wrong");
   property p_id; wr && paddr == 10'h3BD |=> !integration_mode ||
      trace_source_id_out == $past(pwdata[6:0]); endproperty
   a_id: assert property (p_id) else $error("id pins wrong");
   property p_ctl; wr && paddr == 10'h3BE |=> !integration_mode || {trace_byte_count_out,
      flush_ready_out, trace_valid_out} == {$past(pwdata[9:8]), $past(pwdata[1:0])}; endproperty
   a_ctl: assert property (p_ctl) else $error("bus control pins wrong");
   property p_bin; rs && paddr == 10'h3BC |=> prdata[31:2] == 30'h00000000; endproperty
   a_bin: assert property (p_bin) else $error("bus input upper bits set");
   property p_func; !integration_mode |-> trace_valid_out == func_trace_valid_out; endproperty
   a_func: assert property (p_func) else $error("valid pin not functional");
endmodule
bind tir_regs tir_regs_props p_u (.*);
`default_nettype wire

// ### verification/tir_apb_host.sv
/*
 * apb master standing in for integration test software.
 * assumes the slave answers on pready; one transfer at a time.
 */
`timescale 1ns/1ps
`default_nettype none
module tir_apb_host (
   // clock and answer
   input  wire             clk,
   input  wire [31:0]      prdata,
   input  wire             pready,
   // request
   output var logic        psel,
   output var logic        penable,
   output var logic        pwrite,
   output var logic [11:2] paddr,
   output var logic [31:0] pwdata
);
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = 45'h0;
   end
   // ==========================================
   // one transfer: setup, access, wait ready
   task xfer(input [11:0] a, input w, input [31:0] d, output [31:0] q);
      begin
         @(posedge clk);
         {psel, pwrite, paddr, pwdata} <= {1'b1, w, a[11:2], d};
         @(posedge clk);
         penable <= 1'b1;
         @(posedge clk);
         while (pready !== 1'b1) @(posedge clk);
         q = prdata;
         // released lines change so a stale value is never trusted
         {psel, penable, paddr, pwdata} <= {2'h0, ~a[11:2], ~d};
      end
   endtask
endmodule
`default_nettype wire

// ### verification/test_tir_regs.sv
/*
 * register-level bench for the integration-test register block.
 * assumes the apb host model and the bound checker are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module test_tir_regs;
   reg         clk = 1'b0;
   reg         srst = 1'b1;
   reg  [47:0] fv = 48'h0;
   reg  [7:0]  iv = 8'h0;
   reg  [31:0] q;
   integer     n_mismatch = 0;
   integer     check_count = 0;
   integer     cyc = 0;
   integer     k;
   wire        psel, penable, pwrite, pready, im, se;
   wire [11:2] paddr;
   wire [31:0] pwdata, prdata;
   wire [47:0] pv;
   always #10 clk = ~clk;
   tir_apb_host h_u (.clk(clk), .prdata(prdata), .pready(pready), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   tir_regs dut_u (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .paddr(paddr),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(se),
      .func_ext_output_resource(fv[47:46]), .func_idle_ack_n(fv[45]),
      .func_debug_request_out(fv[44]), .func_trigger_occurred_out(fv[43]),
      .func_trace_data_out(fv[42:11]), .func_trace_source_id_out(fv[10:4]),
      .func_trace_byte_count_out(fv[3:2]), .func_flush_ready_out(fv[1]),
      .func_trace_valid_out(fv[0]), .ext_output_resource(pv[47:46]), .idle_ack_n(pv[45]),
      .debug_request_out(pv[44]), .trigger_occurred_out(pv[43]), .trace_data_out(pv[42:11]),
      .trace_source_id_out(pv[10:4]), .trace_byte_count_out(pv[3:2]),
      .flush_ready_out(pv[1]), .trace_valid_out(pv[0]), .cpu_wfi_standby(iv[7]),
      .debug_ack_in(iv[6]), .ext_input_resource(iv[5:2]), .flush_valid_in(iv[1]),
      .trace_ready_in(iv[0]), .integration_mode(im));
   // ==========================================
   // checking and bus tasks
   task chk(input [63:0] nm, input [47:0] e, input [47:0] g);
      begin
         check_count = check_count + 1;
         if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %0s exp %h got %h", nm, e, g);
         end
      end
   endtask
   task w(input [11:0] a, input [31:0] d);
      h_u.xfer(a, 1'b1, d, q);
   endtask
   task r(input [11:0] a, input [31:0] e);
      begin
         h_u.xfer(a, 1'b0, 32'h0, q);
         chk("read", {16'h0, e}, {16'h0, q});
      end
   endtask
   task ov(input [9:0] m, input t, input [4:0] d, input [6:0] i, input [9:0] c);
      begin
         w(12'hEDC, {22'h0, m[9:8], 2'h0, m[5:4], 4'h0});
         w(12'hEE8, {31'h0, t});
         w(12'hEEC, {27'h0, d});
         w(12'hEF4, {25'h0, i});
         w(12'hEF8, {22'h0, c[9:8], 6'h0, c[1:0]});
      end
   endtask
   function [47:0] ex(input [9:0] m, input t, input [4:0] d, input [6:0] i, input [9:0] c);
      ex = {m[9:8], m[5:4], t, d[4], 7'h0, d[3], 7'h0, d[2], 7'h0, d[1], 6'h0, d[0],
         i, c[9:8], c[1:0]};
   endfunction
   task summarize;
      begin
         $display("checks %0d mismatches %0d", check_count, n_mismatch);
         if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch = n_mismatch + 1;
         summarize;
      end
   end
   // ==========================================
   // scenarios
   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      fv <= 48'hA5A55A5AC3C3;
      iv <= 8'hFF;
      @(posedge clk);
      chk("mode", 48'h0, {47'h0, im});
      ov(10'h330, 1'b1, 5'h1F, 7'h7F, 10'h303);
      #1 chk("pins", fv, pv);
      r(12'hEE0, 32'h0);
      r(12'h314, 32'h00000001);
      chk("apb resp", 48'h2, {46'h0, pready, se});
      r(12'h000, 32'h0);
      w(12'hF00, 32'h1);
      r(12'hF00, 32'h1);
      #1 chk("pins", ex(10'h330, 1'b1, 5'h1F, 7'h7F, 10'h303), pv);
      ov(10'h210, 1'b0, 5'h0A, 7'h55, 10'h201);
      #1 chk("pins", ex(10'h210, 1'b0, 5'h0A, 7'h55, 10'h201), pv);
      for (k = 0; k < 2; k = k + 1) begin
         @(posedge clk);
         iv <= k ? 8'h56 : 8'hA9;
         @(posedge clk);
         r(12'hEE0, {26'h0, iv[7:2]});
         r(12'hEF0, {30'h0, iv[1:0]});
      end
      r(12'hEDC, 32'h0);
      w(12'hF00, 32'h0);
      #1 chk("pins", fv, pv);
      w(12'hF00, 32'h1);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk("mode", 48'h0, {47'h0, im});
      chk("pins", fv, pv);
      summarize;
   end
endmodule
`default_nettype wire
